// ---- inc/dsr_pkg.sv ----
// Purpose: constants and types of the decorated store read-modify-write unit
// Assumes: single clock, bus-style address/data phases, 32-bit data
// Notes:   shared by the bridge and the modify datapath
package dsr_pkg;

	// ------------------------------------------------------------
	// address decoration layout
	// ------------------------------------------------------------
	localparam int             ADDR_TOP_BIT  = 31;
	localparam int             REGION_HI     = 30;
	localparam int             REGION_LO     = 29;
	localparam int             OP_HI         = 28;
	localparam int             OP_LO         = 26;
	localparam int             FIELD_BIT     = 28;
	localparam int             POS_HI        = 27;
	localparam int             POS_LO        = 23;
	localparam int             WID_HI        = 22;
	localparam int             WID_LO        = 19;
	localparam int             LOGIC_OFS_HI  = 19;
	localparam int             FIELD_OFS_HI  = 18;
	localparam logic [1:0]     REGION_MEM    = 2'h1;
	localparam logic [1:0]     REGION_PERIPH = 2'h2;
	localparam logic [2:0]     OPCODE_OR     = 3'h2;
	localparam logic [2:0]     OPCODE_XOR    = 3'h3;
	localparam logic [31:0]    BASE_MEM      = 32'h2000_0000;
	localparam logic [31:0]    BASE_PERIPH   = 32'h4000_0000;

	// ------------------------------------------------------------
	// transfer attribute encodings
	// ------------------------------------------------------------
	localparam logic [2:0]     SIZE_BYTE     = 3'h0;
	localparam logic [2:0]     SIZE_HALF     = 3'h1;
	localparam logic [2:0]     SIZE_WORD     = 3'h2;
	localparam logic [1:0]     TRANS_IDLE    = 2'h0;
	localparam logic [1:0]     TRANS_NONSEQ  = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] addr;
		logic [1:0]  trans;
		logic        write;
		logic [2:0]  size;
		logic [2:0]  burst;
		logic [3:0]  prot;
	} dsr_aphase_t;

	typedef enum logic [1:0] {
		DSR_OP_OR    = 2'h0,
		DSR_OP_XOR   = 2'h1,
		DSR_OP_FIELD = 2'h2
	} dsr_op_t;

	// gray sequence idle -> read -> write
	typedef enum logic [1:0] {
		DSR_ST_IDLE  = 2'h0,
		DSR_ST_READ  = 2'h1,
		DSR_ST_WRITE = 2'h3
	} dsr_state_t;

endpackage // dsr_pkg

// ---- core/dsr_modify.sv ----
// Purpose: combinational modify step of a decorated store
// Assumes: write data replicated across lanes by the master
// Notes:   result is replicated across lanes; only sized lanes are written
module dsr_modify (
	input  wire dsr_pkg::dsr_op_t op,
	input  wire logic [2:0]       size,
	input  wire logic [1:0]       lane,
	input  wire logic [4:0]       pos,
	input  wire logic [3:0]       wid,
	input  wire logic [31:0]      rdata,
	input  wire logic [31:0]      wdata,
	output logic      [31:0]      result
);
	import dsr_pkg::*;

	logic [31:0] r_c;
	logic [31:0] w_c;
	logic [31:0] mask;
	logic [31:0] res_c;
	logic [4:0]  shamt;

	always_comb begin
		shamt = 5'h0;
		mask  = 32'h0;
		res_c = 32'h0;
		// container starts at the addressed lane
		if (size == SIZE_BYTE)
			shamt = {lane, 3'h0};
		else if (size == SIZE_HALF)
			shamt = {lane[1], 4'h0};
		r_c = rdata >> shamt;
		w_c = wdata >> shamt;
		case (op)
			DSR_OP_OR:    res_c = r_c | w_c;
			DSR_OP_XOR:   res_c = r_c ^ w_c;
			DSR_OP_FIELD: begin
				mask  = ((32'h2 << wid) - 32'h1) << pos;
				res_c = (w_c & mask) | (r_c & ~mask);
			end
			default:      res_c = r_c;
		endcase
		case (size)
			SIZE_BYTE: result = {4{res_c[7:0]}};
			SIZE_HALF: result = {2{res_c[15:0]}};
			default:   result = res_c;
		endcase
	end

endmodule // dsr_modify

// ---- core/dsr_bridge.sv ----
// Purpose: decorated store bridge between a bus master and slave controllers
// Assumes: master, memory and peripheral controllers share clk
// Notes:   only OR, XOR and field insert stores are decorated;
//          every other transfer passes through untouched
module dsr_bridge (
	input  wire logic                clk,
	input  wire logic                nrst,
	input  wire dsr_pkg::dsr_aphase_t us_ap,
	input  wire logic                us_hready,
	input  wire logic [31:0]         us_hwdata,
	output logic      [31:0]         us_hrdata,
	output logic                     us_hreadyout,
	output logic                     us_hresp,
	output dsr_pkg::dsr_aphase_t     ds_ap,
	output logic      [31:0]         ds_hwdata,
	input  wire logic [31:0]         ds_hrdata,
	input  wire logic                ds_hready,
	input  wire logic                ds_hresp
);
	import dsr_pkg::*;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// decoration decode
	// ------------------------------------------------------------
	logic        in_mem;
	logic        in_periph;
	logic        is_or;
	logic        is_xor;
	logic        is_field;
	logic        decorated;
	logic        take;
	dsr_op_t     dec_op;
	logic [31:0] real_addr;

	always_comb begin
		in_mem    = !us_ap.addr[ADDR_TOP_BIT] &&
		            us_ap.addr[REGION_HI:REGION_LO] == REGION_MEM;
		in_periph = !us_ap.addr[ADDR_TOP_BIT] &&
		            us_ap.addr[REGION_HI:REGION_LO] == REGION_PERIPH;
		is_field  = us_ap.addr[FIELD_BIT];
		is_or     = us_ap.addr[OP_HI:OP_LO] == OPCODE_OR;
		is_xor    = us_ap.addr[OP_HI:OP_LO] == OPCODE_XOR;
		decorated = (in_mem || in_periph) && us_ap.write &&
		            us_ap.trans[1] && (is_field || is_or || is_xor);
		// start only when the previous data phase ends
		take      = decorated && us_hready;
		if (is_field)
			dec_op = DSR_OP_FIELD;
		else if (is_xor)
			dec_op = DSR_OP_XOR;
		else
			dec_op = DSR_OP_OR;
		// base plus offset, don't-care bits dropped
		real_addr = in_mem ? BASE_MEM : BASE_PERIPH;
		if (is_field)
			real_addr[FIELD_OFS_HI:0] = us_ap.addr[FIELD_OFS_HI:0];
		else
			real_addr[LOGIC_OFS_HI:0] = us_ap.addr[LOGIC_OFS_HI:0];
	end

	// ------------------------------------------------------------
	// sequence state and captured transfer
	// ------------------------------------------------------------
	dsr_state_t  state;
	dsr_state_t  next_state;
	dsr_aphase_t cap_ap;
	dsr_aphase_t next_cap_ap;
	dsr_op_t     cap_op;
	dsr_op_t     next_cap_op;
	logic [4:0]  cap_pos;
	logic [4:0]  next_cap_pos;
	logic [3:0]  cap_wid;
	logic [3:0]  next_cap_wid;
	logic [31:0] mod_data;
	logic [31:0] next_mod_data;
	logic [31:0] mod_result;

	dsr_modify u_modify (
		.op     (cap_op),
		.size   (cap_ap.size),
		.lane   (cap_ap.addr[1:0]),
		.pos    (cap_pos),
		.wid    (cap_wid),
		.rdata  (ds_hrdata),
		.wdata  (us_hwdata),
		.result (mod_result)
	);

	always_comb begin
		next_state    = state;
		next_cap_ap   = cap_ap;
		next_cap_op   = cap_op;
		next_cap_pos  = cap_pos;
		next_cap_wid  = cap_wid;
		next_mod_data = mod_data;
		case (state)
			DSR_ST_IDLE, DSR_ST_WRITE: begin
				// new address phase taken during x+2
				if (take) begin
					next_cap_ap      = us_ap;
					next_cap_ap.addr = real_addr;
					next_cap_op      = dec_op;
					next_cap_pos     = us_ap.addr[POS_HI:POS_LO];
					next_cap_wid     = us_ap.addr[WID_HI:WID_LO];
					next_state       = DSR_ST_READ;
				end else if (state == DSR_ST_WRITE && ds_hready) begin
					next_state = DSR_ST_IDLE;
				end
			end
			DSR_ST_READ: begin
				if (ds_hready) begin
					next_mod_data = mod_result;
					next_state    = DSR_ST_WRITE;
				end
			end
			default: next_state = DSR_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= DSR_ST_IDLE;
			cap_ap   <= '0;
			cap_op   <= DSR_OP_OR;
			cap_pos  <= 5'h0;
			cap_wid  <= 4'h0;
			mod_data <= 32'h0;
		end else begin
			state    <= next_state;
			cap_ap   <= next_cap_ap;
			cap_op   <= next_cap_op;
			cap_pos  <= next_cap_pos;
			cap_wid  <= next_cap_wid;
			mod_data <= next_mod_data;
		end
	end

	// ------------------------------------------------------------
	// output steering
	// ------------------------------------------------------------
	// pass-through paths must stay combinational to add no latency
	always_comb begin
		ds_ap        = us_ap;
		ds_hwdata    = us_hwdata;
		us_hrdata    = ds_hrdata;
		us_hresp     = ds_hresp;
		us_hreadyout = ds_hready;
		if (state == DSR_ST_READ) begin
			ds_ap       = cap_ap;
			ds_ap.trans = TRANS_NONSEQ;
			ds_ap.write = 1'b1;
			// stall master in first data phase
			us_hreadyout = 1'b0;
		end else if (decorated) begin
			ds_ap.addr  = real_addr;
			ds_ap.write = 1'b0;
		end
		if (!rst_n)
			ds_ap.trans = TRANS_IDLE;
		if (state == DSR_ST_WRITE)
			ds_hwdata = mod_data;
	end

endmodule // dsr_bridge

// ---- testbench/dsr_bridge_monitor.sv ----
// Purpose: port checker of the decorated store bridge
// Assumes: us_hready fed back from us_hreadyout
// Notes:   result checks cover word stores only
module dsr_bridge_monitor (
	input wire logic                 clk,
	input wire logic                 nrst,
	input wire dsr_pkg::dsr_aphase_t us_ap,
	input wire logic                 us_hready,
	input wire logic [31:0]          us_hwdata,
	input wire logic [31:0]          us_hrdata,
	input wire logic                 us_hreadyout,
	input wire logic                 us_hresp,
	input wire dsr_pkg::dsr_aphase_t ds_ap,
	input wire logic [31:0]          ds_hwdata,
	input wire logic [31:0]          ds_hrdata,
	input wire logic                 ds_hready,
	input wire logic                 ds_hresp
);
	timeunit 1ns;
	timeprecision 1ns;
	import dsr_pkg::*;
	wire [1:0]  rg = us_ap.addr[30:29];
	wire [2:0]  op = us_ap.addr[28:26];
	wire        tk = us_hready && us_ap.trans[1];
	wire        dec = tk && us_ap.write && !us_ap.addr[31]
		&& rg[0] != rg[1] && (op[2] || op[2:1] == 2'h1);
	// field insert gives up offset bit 19 to the width
	wire [31:0] strip = (rg == REGION_MEM ? BASE_MEM : BASE_PERIPH)
		| us_ap.addr[19:0] & {~op[2], 19'h7ffff};
	wire        ww = dec && us_ap.size == SIZE_WORD;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_op(c);
		ww && op == c ##1 ds_hready;
	endsequence
	a_strip_read: assert property (dec |->
		!ds_ap.write && ds_ap.addr == strip) else $error("bad read phase");
	a_write_again: assert property (dec |=>
		ds_ap.write && ds_ap.addr == $past(strip)
		&& ds_ap.size == $past(us_ap.size)) else $error("bad write");
	a_stall_first: assert property (dec |=>
		!us_hreadyout) else $error("no stall");
	a_or_word: assert property (s_op(OPCODE_OR) |=>
		ds_hwdata == ($past(ds_hrdata) | $past(us_hwdata))
		&& us_hreadyout == ds_hready) else $error("bad or data");
	a_xor_word: assert property (s_op(OPCODE_XOR) |=>
		ds_hwdata == ($past(ds_hrdata) ^ $past(us_hwdata))
		&& us_hreadyout == ds_hready) else $error("bad xor data");
	a_plain_pass: assert property (tk && !dec |->
		ds_ap == us_ap) else $error("plain address altered");
	a_plain_ready: assert property (tk && !dec |=>
		us_hreadyout == ds_hready && ds_hwdata == us_hwdata)
		else $error("plain data phase altered");
	a_resp_pass: assert property (us_hrdata == ds_hrdata
		&& us_hresp == ds_hresp && (ds_hready || !us_hreadyout))
		else $error("wait or response lost");
endmodule // dsr_bridge_monitor

bind dsr_bridge dsr_bridge_monitor mon (.clk, .nrst, .us_ap, .us_hready,
	.us_hwdata, .us_hrdata, .us_hreadyout, .us_hresp, .ds_ap, .ds_hwdata,
	.ds_hrdata, .ds_hready, .ds_hresp);

// ---- testbench/dsr_mem_model.sv ----
// Purpose: word memory slave behind the bridge
// Assumes: sixteen words, aliased over both regions
// Notes:   slow puts one wait state in each data phase of an active transfer
module dsr_mem_model (
	input  wire logic                 clk,
	input  wire logic                 slow,
	input  wire dsr_pkg::dsr_aphase_t ap,
	input  wire logic [31:0]          wdata,
	output logic      [31:0]          rdata,
	output logic                      ready,
	output logic                      resp
);
	timeunit 1ns;
	timeprecision 1ns;
	import dsr_pkg::*;
	dsr_aphase_t dp;
	logic [31:0] mem [16];
	logic [31:0] junk = 32'h5a5a_a5a5;
	logic        act = 1'b0;
	logic        hold = 1'b0;
	assign ready = !hold;
	// a stuck response would let a broken pass-through go unseen
	assign resp = act && hold && junk[0];
	// stale data would hide a late sample, so the bus toggles
	assign rdata = act && !dp.write && ready ? mem[dp.addr[5:2]] : junk;
	always @(posedge clk) begin
		junk <= ~junk;
		hold <= ready && slow && ap.trans[1];
		if (ready) begin
			act <= ap.trans[1];
			dp <= ap;
		end
		for (int i = 0; i < 4; i++)
			if (ready && act && dp.write && (dp.size == SIZE_WORD
				|| dp.size[0] && dp.addr[1] == i[1] || dp.addr[1:0] == i[1:0]))
				mem[dp.addr[5:2]][8*i +: 8] <= wdata[8*i +: 8];
	end
endmodule // dsr_mem_model

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench of the decorated store bridge
// Assumes: one master; us_hready fed back from us_hreadyout
// Notes:   results are read back with plain word loads
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import dsr_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        slow = 1'b0;
	dsr_aphase_t us_ap = '0;
	dsr_aphase_t ds_ap;
	logic [31:0] us_hwdata = '0;
	logic [31:0] us_hrdata, ds_hwdata, ds_hrdata;
	logic        us_hreadyout, us_hresp, ds_hready, ds_hresp;
	logic [31:0] pend = '0, rd, a, wd;
	logic [31:0] sh [16];
	logic [3:0]  ix [2];
	logic [2:0]  sz;
	integer      seed = 32'h10c5;
	int          n_mismatch = 0, checks = 0, cyc = 0;

	dsr_bridge dut (.clk, .nrst, .us_ap, .us_hready(us_hreadyout),
		.us_hwdata, .us_hrdata, .us_hreadyout, .us_hresp, .ds_ap,
		.ds_hwdata, .ds_hrdata, .ds_hready, .ds_hresp);
	dsr_mem_model mem (.clk, .slow, .ap(ds_ap), .wdata(ds_hwdata),
		.rdata(ds_hrdata), .ready(ds_hready), .resp(ds_hresp));

	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic results();
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t read %h expected %h", $time, seen, exp);
		end
	endtask

	// pipelined: data of the previous phase goes out with this address
	task automatic ph(input logic [31:0] ad, input logic [1:0] tr,
		input logic wr, input logic [2:0] s, input logic [31:0] d);
		us_ap = '{ad, tr, wr, s, 3'h0, 4'h3};
		us_hwdata = pend;
		// look once settled, never in the time step of the edge
		#1;
		while (us_hreadyout !== 1'b1) begin
			@(negedge clk);
			#1;
		end
		rd = us_hrdata;
		pend = d;
		@(negedge clk);
	endtask

	function automatic logic [31:0] upd(logic [31:0] m, ad, d,
		logic [2:0] s);
		int          n;
		logic [31:0] k, r;
		n = s == SIZE_WORD ? 0 : s == SIZE_HALF ? 16 * ad[1] : 8 * ad[1:0];
		k = (32'h2 << ad[22:19]) - 1 << ad[27:23];
		r = ad[28] ? m >> n & ~k | d & k : ad[26] ? m >> n ^ d : m >> n | d;
		// bits past the container are dropped here
		k = (32'h1 << (8 << s)) - 1 << n;
		return m & ~k | r << n & k;
	endfunction

	initial begin
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 16; i++) begin
			sh[i] = $random(seed);
			ph(BASE_PERIPH | 4 * i, TRANS_NONSEQ, 1'b1, SIZE_WORD, sh[i]);
		end
		for (int n = 0; n < 150; n++) begin
			for (int j = 0; j < 2; j++) begin
				a = $random(seed);
				wd = $random(seed);
				sz = {1'b0, a[31:30] % 2'h3};
				slow = a[10];
				// field straddling the top of a byte
				if (n == 0) begin
					a[7] = 1'b1;
					a[27:19] = {5'h7, 4'h2};
					sz = SIZE_BYTE;
				end
				a[31:26] = {1'b0, a[9] ? REGION_MEM : REGION_PERIPH,
					a[7] ? {1'b1, a[27:26]} : {2'h1, a[6]}};
				a[18:6] = '0;
				a[19] &= a[28];
				a[1:0] &= {sz != SIZE_WORD, sz == SIZE_BYTE};
				ix[j] = a[5:2];
				wd = sz == SIZE_BYTE ? {4{wd[7:0]}}
					: sz == SIZE_HALF ? {2{wd[15:0]}} : wd;
				sh[ix[j]] = upd(sh[ix[j]], a, wd, sz);
				ph(a, TRANS_NONSEQ, 1'b1, sz, wd);
			end
			for (int j = 0; j < 3; j++) begin
				ph(BASE_MEM | {ix[j % 2], 2'h0},
					j < 2 ? TRANS_NONSEQ : TRANS_IDLE, 1'b0, SIZE_WORD, '0);
				if (j > 0)
					chk(rd, sh[ix[j - 1]]);
			end
		end
		results();
	end
endmodule // testbench
